// ### core/fpau_defs.vh
// Constants of the single-precision arithmetic unit
`ifndef FPAU_DEFS_VH
`define FPAU_DEFS_VH

`define FPAU_OP_ADD        10'h1C6
`define FPAU_OP_SUB        10'h1C7
`define FPAU_OP_MUL        10'h1C8
`define FPAU_OP_DIV        10'h1C9

`define FPAU_REG_CTRL      8'h00
`define FPAU_REG_OPA_LO    8'h04
`define FPAU_REG_OPA_HI    8'h08
`define FPAU_REG_OPB_LO    8'h0C
`define FPAU_REG_OPB_HI    8'h10
`define FPAU_REG_RES_LO    8'h14
`define FPAU_REG_RES_HI    8'h18
`define FPAU_REG_FLAGS     8'h1C
`define FPAU_REG_INT_STAT  8'h20
`define FPAU_REG_INT_EN    8'h24
`define FPAU_REG_INT_CLR   8'h28

`define FPAU_FLG_ERR       0
`define FPAU_FLG_ZERO      1
`define FPAU_FLG_OVF       2
`define FPAU_FLG_UNF       3
`define FPAU_FLG_NEG       4
`define FPAU_FLG_BUSY      5

`define FPAU_INT_DONE      0
`define FPAU_INT_ERR       1
`define FPAU_INT_OVF       2
`define FPAU_INT_UNF       3

`define FPAU_RST_OP        10'h000
`define FPAU_RST_WORD      16'h0000
`define FPAU_RST_RES       32'h00000000
`define FPAU_RST_FLAGS     5'h00
`define FPAU_RST_INT       4'h0
`define FPAU_FLAGS_ERROR   5'h01

`define FPAU_DIV_STEPS     5'h1B
`define FPAU_EXP_ALL1      8'hFF
`define FPAU_EXP_TOP       11'h0FF
`define FPAU_MUL_BIAS      11'h07E
`define FPAU_DIV_BIAS      11'h07F
`define FPAU_INF_MAG       31'h7F800000

`endif

// ### core/fpau_top.v
// Single-precision add/sub/mul/div unit with APB register access
//
// Summary of operation
// RULE1: Add code sums both operands into result
// RULE2: Subtract code computes first minus second operand
// RULE3: Multiply code multiplies both operands into result
// RULE4: Divide code divides first operand by second
// RULE5: Operands, result are two 16-bit words
// RULE6: NaN operand sets error; otherwise error clears
// RULE7: Adding opposite infinities sets error
// RULE8: Subtracting like-signed infinities sets error
// RULE9: Infinity times zero sets error
// RULE10: Zero/zero or infinity/infinity sets error
// RULE11: On error the result words stay unwritten
// RULE12: Zero flag when exponent and mantissa zero
// RULE13: Too large gives overflow and signed infinity
// RULE14: Too small gives underflow and zero
// RULE15: Negative flag when result is negative
// RULE16: Finite add/sub may give zero, numeral, infinity
// RULE17: Zero passes other operand; infinity dominates finite
// RULE18: Start on command, one-cycle done pulse
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fpau_defs.vh"

module fpau_top (
    input  wire        CLK_SYS,
    input  wire        SYS_RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output reg         PSLVERR,
    output wire        BUSY,
    output reg         DONE,
    output wire        IRQ
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DIV  = 3'h1;
    localparam [2:0] ST_NORM = 3'h2;
    localparam [2:0] ST_RND  = 3'h3;
    localparam [2:0] ST_FIN  = 3'h4;

    function f_nan;
        input [31:0] x;
        f_nan = (x[30:23] == `FPAU_EXP_ALL1) && (x[22:0] != 23'h000000);
    endfunction

    function f_inf;
        input [31:0] x;
        f_inf = (x[30:23] == `FPAU_EXP_ALL1) && (x[22:0] == 23'h000000);
    endfunction

    // Subnormals are taken as zero, the same way results below normal are
    function f_zero;
        input [31:0] x;
        f_zero = (x[30:23] == 8'h00);
    endfunction

    reg  [9:0]         op_r;
    reg  [15:0]        opa_lo_r;
    reg  [15:0]        opa_hi_r;
    reg  [15:0]        opb_lo_r;
    reg  [15:0]        opb_hi_r;
    reg  [31:0]        res_r;
    reg  [4:0]         flags_r;
    reg  [3:0]         int_stat_r;
    reg  [3:0]         int_en_r;
    reg                go_r;
    reg  [2:0]         state_r;
    reg                sgn_r;
    reg  signed [10:0] exp_r;
    reg  [27:0]        man_r;
    reg                stk_r;
    reg  [24:0]        rem_r;
    reg  [23:0]        dvs_r;
    reg  [4:0]         cnt_r;
    reg  [31:0]        fin_word_r;
    reg                fin_err_r;
    reg                fin_ovf_r;
    reg                fin_unf_r;

    wire [31:0] opa = {opa_hi_r, opa_lo_r}; // RULE5
    wire [31:0] opb = {opb_hi_r, opb_lo_r}; // RULE5
    wire        na  = f_nan(opa);
    wire        nb  = f_nan(opb);
    wire        ia  = f_inf(opa);
    wire        ib  = f_inf(opb);
    wire        za  = f_zero(opa);
    wire        zb  = f_zero(opb);
    wire [23:0] ma  = {1'b1, opa[22:0]};
    wire [23:0] mb  = {1'b1, opb[22:0]};
    wire        sx  = opa[31] ^ opb[31];

    // Special operands and error detection
    reg        b_sgn;
    reg        err_c;
    reg        spc_c;
    reg [31:0] spc_word;

    always @* begin
        b_sgn    = opb[31] ^ (op_r == `FPAU_OP_SUB);
        err_c    = na | nb; // RULE6
        spc_c    = 1'b1;
        spc_word = {1'b0, 31'h00000000};
        case (op_r)
            `FPAU_OP_ADD, `FPAU_OP_SUB: begin
                // Like signs after the subtrahend flip are legal
                err_c = err_c | (ia & ib & (opa[31] != b_sgn)); // RULE7 RULE8
                if (ia) begin
                    spc_word = {opa[31], `FPAU_INF_MAG}; // RULE17
                end else if (ib) begin
                    spc_word = {b_sgn, `FPAU_INF_MAG}; // RULE17
                end else if (za && zb) begin
                    spc_word = {opa[31] & b_sgn, 31'h00000000};
                end else if (za) begin
                    spc_word = {b_sgn, opb[30:0]}; // RULE17
                end else if (zb) begin
                    spc_word = opa; // RULE17
                end else begin
                    spc_c = 1'b0;
                end
            end
            `FPAU_OP_MUL: begin
                err_c = err_c | (ia & zb) | (za & ib); // RULE9
                if (ia || ib) begin
                    spc_word = {sx, `FPAU_INF_MAG};
                end else if (za || zb) begin
                    spc_word = {sx, 31'h00000000};
                end else begin
                    spc_c = 1'b0;
                end
            end
            `FPAU_OP_DIV: begin
                err_c = err_c | (za & zb) | (ia & ib); // RULE10
                if (ia || zb) begin
                    spc_word = {sx, `FPAU_INF_MAG};
                end else if (ib || za) begin
                    spc_word = {sx, 31'h00000000};
                end else begin
                    spc_c = 1'b0;
                end
            end
            default: begin
                err_c = 1'b1;
            end
        endcase
    end

    // Add/subtract alignment; bits shifted out fold into a sticky bit
    wire        a_big  = (opa[30:0] >= opb[30:0]);
    wire [23:0] big_m  = a_big ? ma : mb;
    wire [23:0] sml_m  = a_big ? mb : ma;
    wire [7:0]  big_e  = a_big ? opa[30:23] : opb[30:23];
    wire [7:0]  dexp   = a_big ? (opa[30:23] - opb[30:23])
                               : (opb[30:23] - opa[30:23]);
    wire [4:0]  sh     = (dexp > 8'h1F) ? 5'h1F : dexp[4:0];
    wire [58:0] wide   = {sml_m, 3'h0, 32'h00000000} >> sh;
    wire        al_stk = |wide[31:0];
    wire        eff_sub = opa[31] ^ b_sgn;
    wire [28:0] big_x  = {1'b0, big_m, 3'h0, 1'b0};
    wire [28:0] sml_x  = {1'b0, wide[58:32], al_stk};
    wire [28:0] as_sum = eff_sub ? (big_x - sml_x) : (big_x + sml_x);

    wire [47:0] prod   = ma * mb;

    // Division step: restoring, one quotient bit per cycle
    wire        div_ge = (rem_r >= {1'b0, dvs_r});
    wire [24:0] div_rm = div_ge ? (rem_r - {1'b0, dvs_r}) : rem_r;

    // Round to nearest even, then range check
    wire        rnd_up = man_r[2] & (man_r[1] | man_r[0] | stk_r | man_r[3]);
    wire [24:0] rnd_m  = {1'b0, man_r[26:3]} + {24'h000000, rnd_up};
    wire signed [10:0] rnd_e = exp_r + {10'h000, rnd_m[24]};

    // APB decode
    wire apb_setup = PSEL & ~PENABLE;
    wire apb_acc   = PSEL & PENABLE;
    wire busy_c    = go_r | (state_r != ST_IDLE);
    reg  [31:0] rd_c;
    reg         bad_c;

    always @* begin
        rd_c  = 32'h00000000;
        bad_c = 1'b0;
        case (PADDR)
            `FPAU_REG_CTRL: begin
                rd_c  = {22'h000000, op_r};
                bad_c = PWRITE & busy_c;
            end
            `FPAU_REG_OPA_LO: begin
                rd_c  = {16'h0000, opa_lo_r};
                bad_c = PWRITE & busy_c;
            end
            `FPAU_REG_OPA_HI: begin
                rd_c  = {16'h0000, opa_hi_r};
                bad_c = PWRITE & busy_c;
            end
            `FPAU_REG_OPB_LO: begin
                rd_c  = {16'h0000, opb_lo_r};
                bad_c = PWRITE & busy_c;
            end
            `FPAU_REG_OPB_HI: begin
                rd_c  = {16'h0000, opb_hi_r};
                bad_c = PWRITE & busy_c;
            end
            `FPAU_REG_RES_LO: begin
                rd_c  = {16'h0000, res_r[15:0]}; // RULE5
                bad_c = PWRITE;
            end
            `FPAU_REG_RES_HI: begin
                rd_c  = {16'h0000, res_r[31:16]}; // RULE5
                bad_c = PWRITE;
            end
            `FPAU_REG_FLAGS: begin
                rd_c  = {26'h0000000, busy_c, flags_r};
                bad_c = PWRITE;
            end
            `FPAU_REG_INT_STAT: begin
                rd_c  = {28'h0000000, int_stat_r};
                bad_c = PWRITE;
            end
            `FPAU_REG_INT_EN: begin
                rd_c  = {28'h0000000, int_en_r};
            end
            `FPAU_REG_INT_CLR: begin
                rd_c  = 32'h00000000;
            end
            default: begin
                bad_c = 1'b1;
            end
        endcase
    end

    // Use the refusal latched at setup: busy may fall between the phases
    wire wr_ok = apb_acc & PWRITE & ~PSLVERR;
    wire [3:0] int_clr = (wr_ok && PADDR == `FPAU_REG_INT_CLR)
                         ? PWDATA[3:0] : 4'h0;
    wire fin   = (state_r == ST_FIN);
    wire [3:0] evt = fin ? {fin_unf_r & ~fin_err_r, fin_ovf_r & ~fin_err_r,
                            fin_err_r, 1'b1} : 4'h0;

    assign PREADY = 1'b1;
    assign BUSY   = busy_c;
    assign IRQ    = |(int_stat_r & int_en_r);

    // Register file and interrupt status
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            PRDATA     <= 32'h00000000;
            PSLVERR    <= 1'b0;
            op_r       <= `FPAU_RST_OP;
            opa_lo_r   <= `FPAU_RST_WORD;
            opa_hi_r   <= `FPAU_RST_WORD;
            opb_lo_r   <= `FPAU_RST_WORD;
            opb_hi_r   <= `FPAU_RST_WORD;
            int_en_r   <= `FPAU_RST_INT;
            int_stat_r <= `FPAU_RST_INT;
            go_r       <= 1'b0;
        end else begin
            if (apb_setup) begin
                PRDATA  <= PWRITE ? 32'h00000000 : rd_c;
                PSLVERR <= bad_c;
            end
            // Start waits one cycle so the opcode is settled
            go_r <= wr_ok && (PADDR == `FPAU_REG_CTRL); // RULE18
            if (wr_ok) begin
                case (PADDR)
                    `FPAU_REG_CTRL:   op_r     <= PWDATA[9:0];
                    `FPAU_REG_OPA_LO: opa_lo_r <= PWDATA[15:0];
                    `FPAU_REG_OPA_HI: opa_hi_r <= PWDATA[15:0];
                    `FPAU_REG_OPB_LO: opb_lo_r <= PWDATA[15:0];
                    `FPAU_REG_OPB_HI: opb_hi_r <= PWDATA[15:0];
                    `FPAU_REG_INT_EN: int_en_r <= PWDATA[3:0];
                    default: ;
                endcase
            end
            // A new event wins over a clear in the same cycle
            int_stat_r <= (int_stat_r & ~int_clr) | evt;
        end
    end

    // Arithmetic sequencer
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_r    <= ST_IDLE;
            sgn_r      <= 1'b0;
            exp_r      <= 11'sh000;
            man_r      <= 28'h0000000;
            stk_r      <= 1'b0;
            rem_r      <= 25'h0000000;
            dvs_r      <= 24'h000000;
            cnt_r      <= 5'h00;
            fin_word_r <= `FPAU_RST_RES;
            fin_err_r  <= 1'b0;
            fin_ovf_r  <= 1'b0;
            fin_unf_r  <= 1'b0;
            res_r      <= `FPAU_RST_RES;
            flags_r    <= `FPAU_RST_FLAGS;
            DONE       <= 1'b0;
        end else begin
            DONE <= fin; // RULE18
            case (state_r)
                ST_IDLE: begin
                    fin_err_r <= err_c;
                    fin_ovf_r <= 1'b0;
                    fin_unf_r <= 1'b0;
                    fin_word_r <= spc_word;
                    if (go_r) begin
                        if (err_c || spc_c) begin
                            state_r <= ST_FIN;
                        end else if (op_r == `FPAU_OP_MUL) begin
                            sgn_r   <= sx; // RULE3
                            exp_r   <= $signed({3'h0, opa[30:23]})
                                     + $signed({3'h0, opb[30:23]})
                                     - $signed(`FPAU_MUL_BIAS);
                            man_r   <= {1'b0, prod[47:21]};
                            stk_r   <= |prod[20:0];
                            state_r <= ST_NORM;
                        end else if (op_r == `FPAU_OP_DIV) begin
                            sgn_r   <= sx; // RULE4
                            exp_r   <= $signed({3'h0, opa[30:23]})
                                     - $signed({3'h0, opb[30:23]})
                                     + $signed(`FPAU_DIV_BIAS);
                            man_r   <= 28'h0000000;
                            rem_r   <= {1'b0, ma};
                            dvs_r   <= mb;
                            cnt_r   <= `FPAU_DIV_STEPS;
                            state_r <= ST_DIV;
                        end else begin
                            sgn_r   <= a_big ? opa[31] : b_sgn; // RULE1 RULE2
                            exp_r   <= $signed({3'h0, big_e});
                            man_r   <= as_sum[28:1];
                            stk_r   <= as_sum[0];
                            state_r <= ST_NORM;
                        end
                    end
                end
                ST_DIV: begin
                    man_r <= {man_r[26:0], div_ge}; // RULE4
                    rem_r <= {div_rm[23:0], 1'b0};
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        stk_r   <= (div_rm != 25'h0000000);
                        state_r <= ST_NORM;
                    end
                end
                ST_NORM: begin
                    if (man_r[27]) begin
                        man_r <= {1'b0, man_r[27:1]};
                        stk_r <= stk_r | man_r[0];
                        exp_r <= exp_r + 11'sh001;
                    end else if (man_r == 28'h0000000) begin
                        // Exact cancellation gives positive zero
                        fin_word_r <= 32'h00000000; // RULE16
                        state_r    <= ST_FIN;
                    end else if (!man_r[26]) begin
                        man_r <= {man_r[26:0], 1'b0};
                        exp_r <= exp_r - 11'sh001;
                    end else begin
                        state_r <= ST_RND;
                    end
                end
                ST_RND: begin
                    if (rnd_e >= $signed(`FPAU_EXP_TOP)) begin
                        fin_word_r <= {sgn_r, `FPAU_INF_MAG}; // RULE13
                        fin_ovf_r  <= 1'b1; // RULE13
                    end else if (rnd_e <= 11'sh000) begin
                        fin_word_r <= {sgn_r, 31'h00000000}; // RULE14
                        fin_unf_r  <= 1'b1; // RULE14
                    end else begin
                        fin_word_r <= {sgn_r, rnd_e[7:0], rnd_m[22:0]};
                    end
                    state_r <= ST_FIN;
                end
                ST_FIN: begin
                    if (fin_err_r) begin
                        flags_r <= `FPAU_FLAGS_ERROR; // RULE6 RULE11
                    end else begin
                        res_r <= fin_word_r; // RULE11
                        flags_r[`FPAU_FLG_ERR]  <= 1'b0; // RULE6
                        flags_r[`FPAU_FLG_ZERO] <=
                            (fin_word_r[30:0] == 31'h00000000); // RULE12
                        flags_r[`FPAU_FLG_OVF]  <= fin_ovf_r; // RULE13
                        flags_r[`FPAU_FLG_UNF]  <= fin_unf_r; // RULE14
                        flags_r[`FPAU_FLG_NEG]  <= fin_word_r[31] &
                            (fin_word_r[30:0] != 31'h00000000); // RULE15
                    end
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### verification/fpau_apb_master.sv
// Bus master standing in for the issuing core
`timescale 1ns/10ps
`default_nettype none
module fpau_apb_master (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // Request stays frozen until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data lines flip so a stale value can never pass as held
        pwdata <= ~d;
        paddr <= ~a;
    endtask
endmodule
`default_nettype wire

// ### verification/fpau_checker.sv
// Port-level assertions for the floating-point unit
`timescale 1ns/10ps
`default_nettype none
`include "fpau_defs.vh"
module fpau_checker (
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        BUSY,
    input wire logic        DONE,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);
    wire logic wr_acc;
    wire logic ctrl_wr;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign ctrl_wr = wr_acc && (PADDR == `FPAU_REG_CTRL);
    AST_READY: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase stalled");
    AST_DONE_PULSE: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    AST_BUSY_START: assert property (ctrl_wr && !PSLVERR |=> BUSY)
        else $error("start did not raise busy");
    AST_DONE_BOUND: assert property ($rose(BUSY) |-> ##[1:80] DONE)
        else $error("operation never completed");
    AST_BUSY_FALL: assert property ($fell(BUSY) |-> DONE)
        else $error("busy fell without done");
    AST_DONE_CAUSE: assert property (DONE |-> $past(BUSY))
        else $error("done without a running operation");
    AST_BUSY_REFUSE: assert property (ctrl_wr && BUSY |-> PSLVERR)
        else $error("start accepted while busy");
    AST_RO_WRITE: assert property (wr_acc && PADDR >= `FPAU_REG_RES_LO
        && PADDR <= `FPAU_REG_INT_STAT |-> PSLVERR)
        else $error("write to read-only word accepted");
    AST_BAD_ADDR: assert property (PSEL && PENABLE && (PADDR[1:0] != 2'h0
        || PADDR > `FPAU_REG_INT_CLR) |-> PSLVERR)
        else $error("unmapped address accepted");
    AST_IRQ_CAUSE: assert property ($rose(IRQ) |->
        DONE || $past(DONE) || $past(wr_acc))
        else $error("interrupt rose without cause");
    cover property (DONE);
    cover property (wr_acc && PSLVERR);
    cover property ($rose(IRQ));
endmodule
bind fpau_top fpau_checker chk_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BUSY(BUSY), .DONE(DONE), .IRQ(IRQ));
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the floating-point unit
`timescale 1ns/10ps
`default_nettype none
`include "fpau_defs.vh"
module tb;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    wire  logic  psel, penable, pwrite, pready, pslverr, busy, done, irq;
    wire  logic [7:0]  paddr;
    wire  logic [31:0] pwdata, prdata;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [31:0] last_res = 32'h00000000;
    always #12.5 clk_sys = ~clk_sys;
    fpau_top dut_u (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUSY(busy),
        .DONE(done), .IRQ(irq));
    fpau_apb_master m_u (.clk(clk_sys), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] q;
        logic        e;
        m_u.xfer(1'b0, a, 32'h00000000, q, e);
        check({31'h0, e}, {31'h0, exp_err});
        if (!exp_err) check(q, exp);
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic exp_err);
        logic [31:0] q;
        logic        e;
        m_u.xfer(1'b1, a, d, q, e);
        check({31'h0, e}, {31'h0, exp_err});
    endtask
    // A flag value of error alone means the old result must survive
    task automatic run_op(input logic [9:0] op, input logic [31:0] a,
                          input logic [31:0] b, input logic [31:0] res,
                          input logic [4:0] flg, input logic poke);
        int n;
        n = 0;
        wr_chk(`FPAU_REG_OPA_HI, {16'h0, a[31:16]}, 1'b0);
        wr_chk(`FPAU_REG_OPA_LO, {16'h0, a[15:0]}, 1'b0);
        wr_chk(`FPAU_REG_OPB_HI, {16'h0, b[31:16]}, 1'b0);
        wr_chk(`FPAU_REG_OPB_LO, {16'h0, b[15:0]}, 1'b0);
        wr_chk(`FPAU_REG_CTRL, {22'h0, op}, 1'b0);
        @(posedge clk_sys);
        check({31'h0, busy}, 32'h1);
        if (poke) begin
            wr_chk(`FPAU_REG_CTRL, {22'h0, `FPAU_OP_SUB}, 1'b1);
            wr_chk(`FPAU_REG_OPB_LO, 32'h0000FFFF, 1'b1);
        end
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, done}, 32'h1);
        if (flg == `FPAU_FLAGS_ERROR) res = last_res;
        else last_res = res;
        rd_chk(`FPAU_REG_RES_HI, {16'h0, res[31:16]}, 1'b0);
        rd_chk(`FPAU_REG_RES_LO, {16'h0, res[15:0]}, 1'b0);
        rd_chk(`FPAU_REG_FLAGS, {27'h0, flg}, 1'b0);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(`FPAU_REG_INT_EN, 32'h0, 1'b0);
        rd_chk(`FPAU_REG_FLAGS, 32'h0, 1'b0);
        rd_chk(8'h2C, 32'h0, 1'b1);
        rd_chk(8'h06, 32'h0, 1'b1);
        run_op(`FPAU_OP_ADD, 32'h3F800000, 32'h3F800000, 32'h40000000,
               5'h00, 1'b0);
        check({31'h0, irq}, 32'h0);
        rd_chk(`FPAU_REG_INT_STAT, 32'h1, 1'b0);
        wr_chk(`FPAU_REG_INT_EN, 32'hF, 1'b0);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        wr_chk(`FPAU_REG_INT_CLR, 32'h1, 1'b0);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        rd_chk(`FPAU_REG_INT_CLR, 32'h0, 1'b0);
        run_op(`FPAU_OP_SUB, 32'h3F800000, 32'h40000000, 32'hBF800000,
               5'h10, 1'b0);
        run_op(`FPAU_OP_MUL, 32'h40000000, 32'h40400000, 32'h40C00000,
               5'h00, 1'b0);
        run_op(`FPAU_OP_DIV, 32'h3F800000, 32'h40800000, 32'h3E800000,
               5'h00, 1'b1);
        run_op(`FPAU_OP_ADD, 32'h3F800000, 32'hBF800000, 32'h00000000,
               5'h02, 1'b0);
        run_op(`FPAU_OP_MUL, 32'hFF000000, 32'h40000000, 32'hFF800000,
               5'h14, 1'b0);
        run_op(`FPAU_OP_MUL, 32'h00800000, 32'h00800000, 32'h00000000,
               5'h0A, 1'b0);
        rd_chk(`FPAU_REG_INT_STAT, 32'hD, 1'b0);
        run_op(`FPAU_OP_ADD, 32'h00000000, 32'h40400000, 32'h40400000,
               5'h00, 1'b0);
        run_op(`FPAU_OP_SUB, 32'h00000000, 32'h40400000, 32'hC0400000,
               5'h10, 1'b0);
        run_op(`FPAU_OP_SUB, 32'h40A00000, 32'h7F800000, 32'hFF800000,
               5'h10, 1'b0);
        wr_chk(`FPAU_REG_INT_CLR, 32'hF, 1'b0);
        run_op(`FPAU_OP_ADD, 32'h7FC00000, 32'h3F800000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_MUL, 32'h3F800000, 32'h7FC00000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_ADD, 32'h7F800000, 32'hFF800000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_SUB, 32'h7F800000, 32'h7F800000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_SUB, 32'hFF800000, 32'hFF800000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_MUL, 32'h7F800000, 32'h00000000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_MUL, 32'h80000000, 32'hFF800000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_DIV, 32'h00000000, 32'h00000000, 32'h0, 5'h01,
               1'b0);
        run_op(`FPAU_OP_DIV, 32'h7F800000, 32'hFF800000, 32'h0, 5'h01,
               1'b0);
        run_op(10'h1CA, 32'h3F800000, 32'h3F800000, 32'h0, 5'h01,
               1'b0);
        rd_chk(`FPAU_REG_INT_STAT, 32'h3, 1'b0);
        wr_chk(`FPAU_REG_RES_HI, 32'h00001234, 1'b1);
        wr_chk(`FPAU_REG_INT_STAT, 32'h0, 1'b1);
        wr_chk(8'h40, 32'h0, 1'b1);
        rd_chk(`FPAU_REG_RES_HI, 32'h0000FF80, 1'b0);
        wr_chk(`FPAU_REG_INT_EN, 32'h0, 1'b0);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        run_op(`FPAU_OP_ADD, 32'h3F800000, 32'h40400000, 32'h40800000,
               5'h00, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
